// ==== pkg/cvc_defs.svh ====
// constants for the code violation counter readout block
`ifndef CVC_DEFS_SVH
`define CVC_DEFS_SVH

`define CVC_ADDR_CHAN_SEL     8'h8c
`define CVC_ADDR_CONTROL      8'h8d
`define CVC_ADDR_COUNT_BYTE   8'h8e
`define CVC_ADDR_PULSE_GLOBAL 8'hc0
`define CVC_ADDR_PART_ID      8'hfe
`define CVC_ADDR_REVISION     8'hff

`define CVC_RST_CHAN_SEL      8'h00
`define CVC_RST_CONTROL       8'h00
`define CVC_RST_PULSE_GLOBAL  8'h00

`define CVC_CHAN_PICK_MSB     3
`define CVC_CHAN_PICK_LSB     0
`define CVC_BIT_ALL_CLEAR     4
`define CVC_BIT_ALL_LATCH     3
`define CVC_BIT_BYTE_PICK     2
`define CVC_BIT_SINGLE_LATCH  1
`define CVC_BIT_SINGLE_CLEAR  0
`define CVC_BIT_PULSE_ENABLE  0

`define CVC_NUM_CHANNELS      8
`define CVC_COUNT_MAX         16'hffff

`define CVC_CLK_PERIOD_NS     40
`define CVC_CLEAR_TIME_NS     1000
`define CVC_CLEAR_CYCLES      ((`CVC_CLEAR_TIME_NS + `CVC_CLK_PERIOD_NS - 1) / `CVC_CLK_PERIOD_NS)
`define CVC_CLEAR_CNT_W       5

`endif

// ==== pkg/cvc_pkg.sv ====
// types for the code violation counter readout block
package cvc_pkg;

  typedef logic [15:0] cvc_count_type;
  typedef logic [7:0]  cvc_byte_type;
  typedef logic [3:0]  cvc_pick_type;

  typedef enum logic [6:0] {
    CVC_SEL_NONE     = 7'b000_0001,
    CVC_SEL_CHAN     = 7'b000_0010,
    CVC_SEL_CONTROL  = 7'b000_0100,
    CVC_SEL_COUNT    = 7'b000_1000,
    CVC_SEL_PULSE    = 7'b001_0000,
    CVC_SEL_PART_ID  = 7'b010_0000,
    CVC_SEL_REVISION = 7'b100_0000
  } cvc_reg_sel_type;

endpackage

// ==== hdl/cvc_chan.sv ====
// one channel: running violation counter and its holding register
`timescale 1ns/1ps
`include "cvc_defs.svh"

module cvc_chan (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // events and commands
  input  wire logic               violation,
  input  wire logic               latch,
  input  wire logic               clear,
  // readout
  output cvc_pkg::cvc_count_type  held_count
);

  cvc_pkg::cvc_count_type count_q;
  cvc_pkg::cvc_count_type count_d;
  cvc_pkg::cvc_count_type hold_q;
  cvc_pkg::cvc_count_type hold_d;

  // sixteen-bit counter
  // saturates so a long unattended run never reads as small
  assign count_d = clear ? '0 :
                   (violation && (count_q != `CVC_COUNT_MAX)) ? count_q + 16'h0001 : count_q;

  assign hold_d = latch ? count_q : hold_q;

  assign held_count = hold_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      hold_q  <= '0;
    end else begin
      count_q <= count_d;
      hold_q  <= hold_d;
    end
  end

endmodule

// ==== hdl/cvc_clr_timer.sv ====
// measures how long a clear bit has been held high
`timescale 1ns/1ps
`include "cvc_defs.svh"

module cvc_clr_timer (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // clear bit level
  input  wire logic req,
  // held for the full clear time
  output logic      met
);

  localparam logic [`CVC_CLEAR_CNT_W-1:0] CLEAR_CYCLES = `CVC_CLEAR_CNT_W'(`CVC_CLEAR_CYCLES);

  logic [`CVC_CLEAR_CNT_W-1:0] cnt_q;
  logic [`CVC_CLEAR_CNT_W-1:0] cnt_d;

  // count hold time, stop at limit
  assign cnt_d = !req ? '0 :
                 (cnt_q == CLEAR_CYCLES) ? cnt_q : cnt_q + {{(`CVC_CLEAR_CNT_W-1){1'b0}}, 1'b1};
  assign met   = req && (cnt_q == CLEAR_CYCLES);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ==== hdl/cvc_top.sv ====
// register bank for reading out per-channel code violation counters
`timescale 1ns/1ps
`include "cvc_defs.svh"

module cvc_top #(
  // identity values; defaults are arbitrary
  parameter logic [7:0] PART_CODE     = 8'h5a,
  parameter logic [7:0] REVISION_CODE = 8'h03
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // line side
  input  wire logic [7:0] violation_pulse,
  input  wire logic [7:0] e1_mode,
  // pulse shaping control
  output logic            e1_custom_pulse_enable,
  output logic      [7:0] custom_pulse_active,
  // clear hold status
  output logic            single_clear_held,
  output logic            all_clear_held
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  cvc_pkg::cvc_reg_sel_type reg_sel;
  wire hit_chan    = (reg_addr == `CVC_ADDR_CHAN_SEL);
  wire hit_control = (reg_addr == `CVC_ADDR_CONTROL);
  wire hit_count   = (reg_addr == `CVC_ADDR_COUNT_BYTE);
  wire hit_pulse   = (reg_addr == `CVC_ADDR_PULSE_GLOBAL);
  wire hit_part    = (reg_addr == `CVC_ADDR_PART_ID);
  wire hit_rev     = (reg_addr == `CVC_ADDR_REVISION);

  assign reg_sel = hit_chan    ? cvc_pkg::CVC_SEL_CHAN :
                   hit_control ? cvc_pkg::CVC_SEL_CONTROL :
                   hit_count   ? cvc_pkg::CVC_SEL_COUNT :
                   hit_pulse   ? cvc_pkg::CVC_SEL_PULSE :
                   hit_part    ? cvc_pkg::CVC_SEL_PART_ID :
                   hit_rev     ? cvc_pkg::CVC_SEL_REVISION : cvc_pkg::CVC_SEL_NONE;

  wire wr_chan    = reg_wr && hit_chan;
  wire wr_control = reg_wr && hit_control;
  wire wr_pulse   = reg_wr && hit_pulse;

  ////////////////////////////////////////////////////////////////////////////
  // writable registers

  // reserved bits are stored and read back as written
  cvc_pkg::cvc_byte_type chan_sel_q;
  cvc_pkg::cvc_byte_type chan_sel_d;
  cvc_pkg::cvc_byte_type control_q;
  cvc_pkg::cvc_byte_type control_d;
  cvc_pkg::cvc_byte_type pulse_q;
  cvc_pkg::cvc_byte_type pulse_d;

  assign chan_sel_d = wr_chan    ? reg_wdata : chan_sel_q;
  assign control_d  = wr_control ? reg_wdata : control_q;
  assign pulse_d    = wr_pulse   ? reg_wdata : pulse_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chan_sel_q <= `CVC_RST_CHAN_SEL;
    end else begin
      chan_sel_q <= chan_sel_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_q <= `CVC_RST_CONTROL;
    end else begin
      control_q <= control_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_q <= `CVC_RST_PULSE_GLOBAL;
    end else begin
      pulse_q <= pulse_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel pick

  wire cvc_pkg::cvc_pick_type chan_pick = chan_sel_q[`CVC_CHAN_PICK_MSB:`CVC_CHAN_PICK_LSB];

  // 0 is none, 1..8 map to 0..7
  wire       pick_valid = (chan_pick != 4'h0) && (chan_pick <= 4'h8);
  wire [3:0] pick_index = chan_pick - 4'h1;

  wire byte_pick    = control_q[`CVC_BIT_BYTE_PICK];
  wire single_clear = control_q[`CVC_BIT_SINGLE_CLEAR];
  wire all_clear    = control_q[`CVC_BIT_ALL_CLEAR];

  // latches fire on the write that carries a 1, not on the stored level,
  // so a latched value stays frozen while software reads both bytes
  wire single_latch_wr = wr_control && reg_wdata[`CVC_BIT_SINGLE_LATCH];
  wire all_latch_wr    = wr_control && reg_wdata[`CVC_BIT_ALL_LATCH];

  ////////////////////////////////////////////////////////////////////////////
  // channels

  cvc_pkg::cvc_count_type held_count [0:`CVC_NUM_CHANNELS-1];
  logic [`CVC_NUM_CHANNELS-1:0] chan_hit;
  logic [`CVC_NUM_CHANNELS-1:0] chan_latch;
  logic [`CVC_NUM_CHANNELS-1:0] chan_clear;

  assign chan_hit[0] = pick_valid && (pick_index == 4'h0);
  assign chan_hit[1] = pick_valid && (pick_index == 4'h1);
  assign chan_hit[2] = pick_valid && (pick_index == 4'h2);
  assign chan_hit[3] = pick_valid && (pick_index == 4'h3);
  assign chan_hit[4] = pick_valid && (pick_index == 4'h4);
  assign chan_hit[5] = pick_valid && (pick_index == 4'h5);
  assign chan_hit[6] = pick_valid && (pick_index == 4'h6);
  assign chan_hit[7] = pick_valid && (pick_index == 4'h7);

  // single latch; all latch
  // a latch write copies the count from before that edge's increment
  assign chan_latch[0] = all_latch_wr || (single_latch_wr && chan_hit[0]);
  assign chan_latch[1] = all_latch_wr || (single_latch_wr && chan_hit[1]);
  assign chan_latch[2] = all_latch_wr || (single_latch_wr && chan_hit[2]);
  assign chan_latch[3] = all_latch_wr || (single_latch_wr && chan_hit[3]);
  assign chan_latch[4] = all_latch_wr || (single_latch_wr && chan_hit[4]);
  assign chan_latch[5] = all_latch_wr || (single_latch_wr && chan_hit[5]);
  assign chan_latch[6] = all_latch_wr || (single_latch_wr && chan_hit[6]);
  assign chan_latch[7] = all_latch_wr || (single_latch_wr && chan_hit[7]);

  // single clear; all clear
  // clear is a level, so a violation in a clearing cycle is lost
  assign chan_clear[0] = all_clear || (single_clear && chan_hit[0]);
  assign chan_clear[1] = all_clear || (single_clear && chan_hit[1]);
  assign chan_clear[2] = all_clear || (single_clear && chan_hit[2]);
  assign chan_clear[3] = all_clear || (single_clear && chan_hit[3]);
  assign chan_clear[4] = all_clear || (single_clear && chan_hit[4]);
  assign chan_clear[5] = all_clear || (single_clear && chan_hit[5]);
  assign chan_clear[6] = all_clear || (single_clear && chan_hit[6]);
  assign chan_clear[7] = all_clear || (single_clear && chan_hit[7]);

  // one instance per channel, each with its own counter and hold
  cvc_chan u_chan0 (
    .clk        (clk),
    .rst        (rst),
    .violation  (violation_pulse[0]),
    .latch      (chan_latch[0]),
    .clear      (chan_clear[0]),
    .held_count (held_count[0])
  );

  cvc_chan u_chan1 (
    .clk        (clk),
    .rst        (rst),
    .violation  (violation_pulse[1]),
    .latch      (chan_latch[1]),
    .clear      (chan_clear[1]),
    .held_count (held_count[1])
  );

  cvc_chan u_chan2 (
    .clk        (clk),
    .rst        (rst),
    .violation  (violation_pulse[2]),
    .latch      (chan_latch[2]),
    .clear      (chan_clear[2]),
    .held_count (held_count[2])
  );

  cvc_chan u_chan3 (
    .clk        (clk),
    .rst        (rst),
    .violation  (violation_pulse[3]),
    .latch      (chan_latch[3]),
    .clear      (chan_clear[3]),
    .held_count (held_count[3])
  );

  cvc_chan u_chan4 (
    .clk        (clk),
    .rst        (rst),
    .violation  (violation_pulse[4]),
    .latch      (chan_latch[4]),
    .clear      (chan_clear[4]),
    .held_count (held_count[4])
  );

  cvc_chan u_chan5 (
    .clk        (clk),
    .rst        (rst),
    .violation  (violation_pulse[5]),
    .latch      (chan_latch[5]),
    .clear      (chan_clear[5]),
    .held_count (held_count[5])
  );

  cvc_chan u_chan6 (
    .clk        (clk),
    .rst        (rst),
    .violation  (violation_pulse[6]),
    .latch      (chan_latch[6]),
    .clear      (chan_clear[6]),
    .held_count (held_count[6])
  );

  cvc_chan u_chan7 (
    .clk        (clk),
    .rst        (rst),
    .violation  (violation_pulse[7]),
    .latch      (chan_latch[7]),
    .clear      (chan_clear[7]),
    .held_count (held_count[7])
  );

  ////////////////////////////////////////////////////////////////////////////
  // clear hold timers

  // report host hold of single clear
  cvc_clr_timer u_single_timer (
    .clk (clk),
    .rst (rst),
    .req (single_clear),
    .met (single_clear_held)
  );

  // report host hold of all clear
  cvc_clr_timer u_all_timer (
    .clk (clk),
    .rst (rst),
    .req (all_clear),
    .met (all_clear_held)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pulse shaping control

  // global enable gated by E1 mode
  assign e1_custom_pulse_enable = pulse_q[`CVC_BIT_PULSE_ENABLE];
  assign custom_pulse_active    = e1_mode & {`CVC_NUM_CHANNELS{e1_custom_pulse_enable}};

  ////////////////////////////////////////////////////////////////////////////
  // read path

  cvc_pkg::cvc_count_type picked_count;
  cvc_pkg::cvc_byte_type  count_byte;
  cvc_pkg::cvc_byte_type  rdata_d;
  cvc_pkg::cvc_byte_type  rdata_q;

  // one-hot pick chain; no pick selects zero
  assign picked_count = chan_hit[0] ? held_count[0] :
                        chan_hit[1] ? held_count[1] :
                        chan_hit[2] ? held_count[2] :
                        chan_hit[3] ? held_count[3] :
                        chan_hit[4] ? held_count[4] :
                        chan_hit[5] ? held_count[5] :
                        chan_hit[6] ? held_count[6] :
                        chan_hit[7] ? held_count[7] :
                        16'h0000;

  wire cvc_pkg::cvc_byte_type count_low  = picked_count[7:0];
  wire cvc_pkg::cvc_byte_type count_high = picked_count[15:8];

  // picked byte of picked channel; zero with no channel
  // byte pick steers high or low
  assign count_byte = !pick_valid ? 8'h00 :
                      byte_pick   ? count_high : count_low;

  // reads only sample, nothing is cleared on read
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      case (reg_sel)
        cvc_pkg::CVC_SEL_CHAN:     rdata_d = chan_sel_q;
        cvc_pkg::CVC_SEL_CONTROL:  rdata_d = control_q;
        cvc_pkg::CVC_SEL_COUNT:    rdata_d = count_byte;
        cvc_pkg::CVC_SEL_PULSE:    rdata_d = pulse_q;
        cvc_pkg::CVC_SEL_PART_ID:  rdata_d = PART_CODE;
        cvc_pkg::CVC_SEL_REVISION: rdata_d = REVISION_CODE;
        default:                   rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule

// ==== verif/cvc_chk.sv ====
// checker for the violation counter readout register bank
`timescale 1ns/1ps
module cvc_chk #(
  parameter logic [7:0] PART_CODE     = 8'h5a,
  parameter logic [7:0] REVISION_CODE = 8'h03
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // line side and status
  input wire logic [7:0] violation_pulse,
  input wire logic [7:0] e1_mode,
  input wire logic       e1_custom_pulse_enable,
  input wire logic [7:0] custom_pulse_active,
  input wire logic       single_clear_held,
  input wire logic       all_clear_held
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire wr_ctl = reg_wr && reg_addr == 8'h8d;
  wire wd0    = reg_wdata[0];
  ////////////////////////////////////////////////////////////////
  chk_part_code: assert property (reg_rd && reg_addr == 8'hfe |=> reg_rdata == PART_CODE)
    else $error("part code read wrong");
  chk_rev_code: assert property (reg_rd && reg_addr == 8'hff |=> reg_rdata == REVISION_CODE)
    else $error("revision read wrong");
  chk_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'h8f |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_pulse_map: assert property (custom_pulse_active == (e1_mode & {8{e1_custom_pulse_enable}}))
    else $error("custom pulse map wrong");
  chk_pulse_write: assert property (reg_wr && reg_addr == 8'hc0 |=> e1_custom_pulse_enable == $past(wd0))
    else $error("pulse enable not written");
  chk_single_drop: assert property (wr_ctl && !reg_wdata[0] |=> !single_clear_held)
    else $error("single clear still held");
  chk_all_drop: assert property (wr_ctl && !reg_wdata[4] |=> !all_clear_held)
    else $error("all clear still held");
  cover property (reg_rd && reg_addr == 8'h8e);
  cover property (wr_ctl && reg_wdata[1]);
  cover property (single_clear_held);
  cover property (all_clear_held);
endmodule
bind cvc_top cvc_chk #(.PART_CODE(PART_CODE), .REVISION_CODE(REVISION_CODE)) cvc_chk_i (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .violation_pulse(violation_pulse), .e1_mode(e1_mode),
  .e1_custom_pulse_enable(e1_custom_pulse_enable), .custom_pulse_active(custom_pulse_active),
  .single_clear_held(single_clear_held), .all_clear_held(all_clear_held));

// ==== verif/cvc_host.sv ====
// host model driving the register port
`timescale 1ns/1ps
`include "cvc_defs.svh"
module cvc_host (
  // clock and read data
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  // request
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata
);
  initial begin
    {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  end
  // one strobe cycle; an edge passes before each new strobe
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {a, d, w, !w};
    @(posedge clk) #1;
    // released port shows stale inverted values
    {reg_addr, reg_wdata, reg_wr, reg_rd} = {~a, ~d, 2'b00};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    acc(1'b0, a, 8'h00);
    d = reg_rdata;
  endtask
  task automatic clr_start(input logic [7:0] bits);
    wr(8'h8d, bits);
    repeat (`CVC_CLEAR_CYCLES + 1) @(posedge clk);
    #1;
  endtask
endmodule

// ==== verif/testbench.sv ====
// self-checking bench for the violation counter readout block
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr, wdata, rdata, vp, e1m, cpa, got;
  logic        wr, rd, cpe, sch, ach;
  logic [15:0] exp_c [8];
  logic [15:0] hold_c [8];
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          seed = 32'h0dcdea4a;
  always #20 clk = ~clk;
  cvc_top #(.PART_CODE(8'h5a), .REVISION_CODE(8'h03)) cvc_top_i (.clk(clk), .rst(rst), .reg_addr(addr),
    .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .violation_pulse(vp), .e1_mode(e1m),
    .e1_custom_pulse_enable(cpe), .custom_pulse_active(cpa), .single_clear_held(sch), .all_clear_held(ach));
  cvc_host cvc_host_i (.clk(clk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata));
  ////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
    cvc_host_i.rd(a, got);
    chk8(nm, e, got);
  endtask
  function automatic logic [7:0] eb(input int ch, input logic hi);
    return hi ? hold_c[ch][15:8] : hold_c[ch][7:0];
  endfunction
  // saturating expected counts follow random pulses
  task automatic pulses(input int n, input logic [7:0] all);
    for (int k = 0; k < n; k++) begin
      @(posedge clk) #1;
      vp = 8'($random(seed)) | all;
      e1m = 8'($random(seed));
      for (int i = 0; i < 8; i++) if (vp[i] && exp_c[i] != 16'hffff) exp_c[i]++;
    end
    @(posedge clk) #1;
    vp = 8'h00;
  endtask
  task automatic read_all(input logic [7:0] ctl);
    for (int ch = 0; ch < 8; ch++) begin
      cvc_host_i.wr(8'h8c, 8'(ch + 1));
      cvc_host_i.wr(8'h8d, ctl);
      if (ctl[1]) hold_c[ch] = exp_c[ch];
      rdc(8'h8e, eb(ch, 1'b0), "count low");
      rdc(8'h8e, eb(ch, 1'b0), "count low again");
      cvc_host_i.wr(8'h8d, 8'h04);
      rdc(8'h8e, eb(ch, 1'b1), "count high");
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    vp = 8'h00;
    e1m = 8'h00;
    foreach (exp_c[i]) exp_c[i] = 16'h0000;
    hold_c = exp_c;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    rdc(8'h8c, 8'h00, "select reset");
    rdc(8'h8d, 8'h00, "control reset");
    rdc(8'h8e, 8'h00, "count reset");
    rdc(8'hc0, 8'h00, "pulse reset");
    cvc_host_i.wr(8'hfe, 8'h00);
    cvc_host_i.wr(8'hff, 8'h00);
    rdc(8'hfe, 8'h5a, "part code");
    rdc(8'hff, 8'h03, "revision");
    rdc(8'h8f, 8'h00, "unmapped");
    $display("test reset done");
    pulses(40, 8'h00);
    read_all(8'h02);
    cvc_host_i.wr(8'h8c, 8'h00);
    rdc(8'h8e, 8'h00, "no channel");
    cvc_host_i.wr(8'h8c, 8'hf9);
    rdc(8'h8c, 8'hf9, "select bits");
    rdc(8'h8e, 8'h00, "pick nine");
    $display("test single latch done");
    pulses(30, 8'h00);
    cvc_host_i.wr(8'h8d, 8'h08);
    hold_c = exp_c;
    pulses(30, 8'h00);
    read_all(8'h00);
    $display("test all latch done");
    cvc_host_i.wr(8'h8c, 8'h04);
    cvc_host_i.clr_start(8'h01);
    chk8("single held", 8'h01, {7'h00, sch});
    cvc_host_i.wr(8'h8d, 8'h00);
    exp_c[3] = 16'h0000;
    read_all(8'h02);
    cvc_host_i.clr_start(8'h10);
    chk8("all held", 8'h01, {7'h00, ach});
    cvc_host_i.wr(8'h8d, 8'h00);
    foreach (exp_c[i]) exp_c[i] = 16'h0000;
    read_all(8'h02);
    $display("test clear done");
    for (int v = 1; v >= 0; v--) begin
      cvc_host_i.wr(8'hc0, 8'(v));
      chk8("pulse enable", 8'(v), {7'h00, cpe});
      pulses(1, 8'h00);
      chk8("custom pulse", e1m & {8{v[0]}}, cpa);
    end
    $display("test pulse enable done");
    pulses(65540, 8'hff);
    read_all(8'h02);
    $display("test saturation done");
    end_sim();
  end
endmodule
